// [rtl/cxerm_pkg.sv]
// Package of constants and types for the receive error monitor
package cxerm_pkg;

    localparam int unsigned CXERM_LINKS = 4;
    localparam int unsigned CXERM_SHORT_W = 13;
    localparam int unsigned CXERM_LONG_W = 25;
    localparam int unsigned CXERM_ADDR_W = 8;
    localparam int unsigned CXERM_DATA_W = 32;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] CXERM_OFS_TAG_JUMP = 8'h00;
    localparam logic [7:0] CXERM_OFS_STREAM_ID = 8'h04;
    localparam logic [7:0] CXERM_OFS_MARKER = 8'h08;
    localparam logic [7:0] CXERM_OFS_STARTUP = 8'h0c;
    localparam logic [7:0] CXERM_OFS_DROPPED = 8'h10;
    localparam logic [7:0] CXERM_OFS_DAMAGED = 8'h14;
    localparam logic [7:0] CXERM_OFS_LINK_SEL = 8'h18;
    localparam logic [7:0] CXERM_OFS_LINK_CRC_CNT = 8'h1c;
    localparam logic [7:0] CXERM_OFS_LINK_FLAGS = 8'h20;
    localparam logic [7:0] CXERM_OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] CXERM_OFS_IRQ_MASK = 8'h28;

    // Link flag register layout
    localparam int unsigned CXERM_FLAG_STREAM_LSB = 0;
    localparam int unsigned CXERM_FLAG_ACK_LSB = 4;

    // Interrupt status bit positions
    localparam int unsigned CXERM_IRQ_TAG = 0;
    localparam int unsigned CXERM_IRQ_SID = 1;
    localparam int unsigned CXERM_IRQ_MARK = 2;
    localparam int unsigned CXERM_IRQ_START = 3;
    localparam int unsigned CXERM_IRQ_DROP = 4;
    localparam int unsigned CXERM_IRQ_DAMAGE = 5;
    localparam int unsigned CXERM_IRQ_CRC = 6;
    localparam int unsigned CXERM_IRQ_W = 7;

    localparam logic [CXERM_IRQ_W-1:0] CXERM_IRQ_RESET = 7'h00;
    localparam logic [1:0] CXERM_SEL_RESET = 2'h0;

    // Error events from the packet decoder, one-cycle pulses
    typedef struct packed {
        logic image_tag_jump;
        logic stream_id_mismatch;
        logic marker_fault;
        logic first_word_valid;
        logic first_word_is_header;
        logic frame_dropped;
        logic frame_damaged;
        logic [CXERM_LINKS-1:0] stream_crc_fail;
        logic [CXERM_LINKS-1:0] ack_crc_fail;
    } cxerm_events_s;

    // Register port request
    typedef struct packed {
        logic [CXERM_ADDR_W-1:0] addr;
        logic [CXERM_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cxerm_bus_s;

    typedef enum logic [1:0] {
        CXERM_WAIT_FIRST = 2'b00,
        CXERM_RUNNING = 2'b01
    } cxerm_start_e;

endpackage : cxerm_pkg

// [rtl/cxerm_sat_counter.sv]
// Error counter with overflow flag above the count field
`timescale 1ns/1ps
`default_nettype none
module cxerm_sat_counter
    import cxerm_pkg::*;
#(
    parameter int unsigned W = CXERM_SHORT_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic inc,
    output logic [W-1:0] value
);
    localparam logic [W-2:0] COUNT_MAX = '1;

    logic [W-2:0] count;
    logic ovf;
    wire wrap = inc && (count == COUNT_MAX);

    // Count keeps wrapping after overflow; software treats it as undefined
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            ovf <= 1'b0;
        end else if (inc) begin
            count <= count + 1'b1;
            if (wrap) begin
                ovf <= 1'b1;
            end
        end
    end

    assign value = {ovf, count};
endmodule : cxerm_sat_counter
`default_nettype wire

// [rtl/cxerm_monitor.sv]
// Receive path error monitor with counters, link flags and interrupt
//
// Summary of operation
// - Count image tag jumps, thirteen bits
// - Count stream identifier mismatches
// - Low twelve bits count, bit twelve overflows
// - Count stream marker ordering faults
// - Flag non-header first word after reset
// - Count frames dropped for header/overlap errors
// - Frame counters: 24-bit count, overflow bit 24
// - Count forwarded frames with damaged pixels
// - Per-link CRC counter read through selector
// - Per-link sticky stream CRC fail flag
// - Per-link sticky acknowledge CRC fail flag
`timescale 1ns/1ps
`default_nettype none
module cxerm_monitor
    import cxerm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire cxerm_events_s events,
    input wire logic [CXERM_ADDR_W-1:0] bus_addr,
    input wire logic [CXERM_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [CXERM_DATA_W-1:0] bus_rdata,
    output logic irq
);
    logic [CXERM_SHORT_W-1:0] tag_jump_value;
    logic [CXERM_SHORT_W-1:0] stream_id_value;
    logic [CXERM_SHORT_W-1:0] marker_value;
    logic [CXERM_LONG_W-1:0] dropped_value;
    logic [CXERM_LONG_W-1:0] damaged_value;
    logic [CXERM_SHORT_W-1:0] link_crc_value [CXERM_LINKS];
    logic [CXERM_LINKS-1:0] link_stream_checksum_fail_flag;
    logic [CXERM_LINKS-1:0] link_ack_checksum_fail_flag;
    logic startup_unexpected_data_flag;
    cxerm_start_e start_state;
    logic [1:0] link_sel;
    logic [CXERM_IRQ_W-1:0] irq_status;
    logic [CXERM_IRQ_W-1:0] irq_mask;
    logic [CXERM_DATA_W-1:0] next_rdata;
    logic [CXERM_IRQ_W-1:0] next_irq_status;

    cxerm_bus_s req;
    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    function automatic logic hit(input logic [CXERM_ADDR_W-1:0] a,
                                 input logic [CXERM_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Event counters
    cxerm_sat_counter #(.W(CXERM_SHORT_W)) u_tag_jump (
        .clk(clk), .reset(reset), .inc(events.image_tag_jump), .value(tag_jump_value)
    );
    cxerm_sat_counter #(.W(CXERM_SHORT_W)) u_stream_id (
        .clk(clk), .reset(reset), .inc(events.stream_id_mismatch), .value(stream_id_value)
    );
    cxerm_sat_counter #(.W(CXERM_SHORT_W)) u_marker (
        .clk(clk), .reset(reset), .inc(events.marker_fault), .value(marker_value)
    );
    cxerm_sat_counter #(.W(CXERM_LONG_W)) u_dropped (
        .clk(clk), .reset(reset), .inc(events.frame_dropped), .value(dropped_value)
    );
    cxerm_sat_counter #(.W(CXERM_LONG_W)) u_damaged (
        .clk(clk), .reset(reset), .inc(events.frame_damaged), .value(damaged_value)
    );

    // A CRC fail on either packet kind counts once per cycle per link
    wire [CXERM_LINKS-1:0] link_crc_event = events.stream_crc_fail | events.ack_crc_fail;

    genvar gi;
    generate
        for (gi = 0; gi < CXERM_LINKS; gi++) begin : g_link
            cxerm_sat_counter #(.W(CXERM_SHORT_W)) u_crc (
                .clk(clk), .reset(reset), .inc(link_crc_event[gi]),
                .value(link_crc_value[gi])
            );
        end
    endgenerate

    // One process owns each flag vector; flags only ever set until reset
    wire [CXERM_LINKS-1:0] next_stream_flags =
        link_stream_checksum_fail_flag | events.stream_crc_fail;
    wire [CXERM_LINKS-1:0] next_ack_flags = link_ack_checksum_fail_flag | events.ack_crc_fail;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link_stream_checksum_fail_flag <= '0;
            link_ack_checksum_fail_flag <= '0;
        end else begin
            link_stream_checksum_fail_flag <= next_stream_flags;
            link_ack_checksum_fail_flag <= next_ack_flags;
        end
    end

    // Only the first word after reset is judged; later words are ignored
    wire first_word_bad = (start_state == CXERM_WAIT_FIRST) && events.first_word_valid &&
                          !events.first_word_is_header;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_state <= CXERM_WAIT_FIRST;
            startup_unexpected_data_flag <= 1'b0;
        end else begin
            case (start_state)
                CXERM_WAIT_FIRST: begin
                    if (events.first_word_valid) begin
                        start_state <= CXERM_RUNNING;
                    end
                    if (first_word_bad) begin
                        startup_unexpected_data_flag <= 1'b1;
                    end
                end
                CXERM_RUNNING: begin
                    start_state <= CXERM_RUNNING;
                end
                default: begin
                    start_state <= CXERM_WAIT_FIRST;
                end
            endcase
        end
    end

    // Interrupt events and write-one-to-clear, set wins over clear
    wire [CXERM_IRQ_W-1:0] irq_events = {
        |link_crc_event,
        events.frame_damaged,
        events.frame_dropped,
        first_word_bad,
        events.marker_fault,
        events.stream_id_mismatch,
        events.image_tag_jump
    };
    wire status_wr = req.wr && hit(req.addr, CXERM_OFS_IRQ_STATUS);
    wire mask_wr = req.wr && hit(req.addr, CXERM_OFS_IRQ_MASK);
    wire sel_wr = req.wr && hit(req.addr, CXERM_OFS_LINK_SEL);
    wire [CXERM_IRQ_W-1:0] clear_bits = status_wr ? req.wdata[CXERM_IRQ_W-1:0] : '0;
    assign next_irq_status = (irq_status & ~clear_bits) | irq_events;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_status <= CXERM_IRQ_RESET;
            irq_mask <= CXERM_IRQ_RESET;
            link_sel <= CXERM_SEL_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (mask_wr) begin
                irq_mask <= req.wdata[CXERM_IRQ_W-1:0];
            end
            if (sel_wr) begin
                link_sel <= req.wdata[1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read decode; counters are never touched by reads
    wire [CXERM_LINKS-1:0] sel_stream = link_stream_checksum_fail_flag;
    wire [CXERM_LINKS-1:0] sel_ack = link_ack_checksum_fail_flag;

    always_comb begin
        next_rdata = '0;
        case (req.addr)
            CXERM_OFS_TAG_JUMP: next_rdata[CXERM_SHORT_W-1:0] = tag_jump_value;
            CXERM_OFS_STREAM_ID: next_rdata[CXERM_SHORT_W-1:0] = stream_id_value;
            CXERM_OFS_MARKER: next_rdata[CXERM_SHORT_W-1:0] = marker_value;
            CXERM_OFS_STARTUP: next_rdata[0] = startup_unexpected_data_flag;
            CXERM_OFS_DROPPED: next_rdata[CXERM_LONG_W-1:0] = dropped_value;
            CXERM_OFS_DAMAGED: next_rdata[CXERM_LONG_W-1:0] = damaged_value;
            CXERM_OFS_LINK_SEL: next_rdata[1:0] = link_sel;
            CXERM_OFS_LINK_CRC_CNT: next_rdata[CXERM_SHORT_W-1:0] = link_crc_value[link_sel];
            CXERM_OFS_LINK_FLAGS: begin
                next_rdata[CXERM_FLAG_STREAM_LSB +: CXERM_LINKS] = sel_stream;
                next_rdata[CXERM_FLAG_ACK_LSB +: CXERM_LINKS] = sel_ack;
            end
            CXERM_OFS_IRQ_STATUS: next_rdata[CXERM_IRQ_W-1:0] = irq_status;
            CXERM_OFS_IRQ_MASK: next_rdata[CXERM_IRQ_W-1:0] = irq_mask;
            default: next_rdata = '0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= req.rd ? next_rdata : '0;
        end
    end
endmodule : cxerm_monitor
`default_nettype wire

// [testbench/cxerm_monitor_checker.sv]
// Checker of register port and event relations
`timescale 1ns/1ps
`default_nettype none
module cxerm_monitor_checker
    import cxerm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire cxerm_events_s events,
    input wire logic [CXERM_ADDR_W-1:0] bus_addr,
    input wire logic [CXERM_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [CXERM_DATA_W-1:0] bus_rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence rd_at(logic [7:0] a);
        bus_rd && bus_addr == a;
    endsequence
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata == '0)
        else $error("read data not idle");
    a_short_width: assert property (
        rd_at(CXERM_OFS_STREAM_ID) or rd_at(CXERM_OFS_LINK_CRC_CNT)
        |=> bus_rdata[31:13] == '0) else $error("short counter too wide");
    a_long_width: assert property (
        rd_at(CXERM_OFS_DROPPED) or rd_at(CXERM_OFS_DAMAGED)
        |=> bus_rdata[31:25] == '0) else $error("frame counter too wide");
    a_start_width: assert property (
        rd_at(CXERM_OFS_STARTUP) |=> bus_rdata[31:1] == '0)
        else $error("startup flag too wide");
    a_stream_sticky: assert property (
        events.stream_crc_fail[0] ##1 rd_at(CXERM_OFS_LINK_FLAGS)
        |=> bus_rdata[CXERM_FLAG_STREAM_LSB]) else $error("stream flag lost");
    a_ack_sticky: assert property (
        events.ack_crc_fail[0] ##1 rd_at(CXERM_OFS_LINK_FLAGS)
        |=> bus_rdata[CXERM_FLAG_ACK_LSB]) else $error("ack flag lost");
    a_tag_count: assert property (
        events.image_tag_jump ##1 rd_at(CXERM_OFS_TAG_JUMP)
        |=> bus_rdata != '0) else $error("tag jump not counted");
    a_drop_count: assert property (
        events.frame_dropped ##1 rd_at(CXERM_OFS_DROPPED)
        |=> bus_rdata != '0) else $error("drop not counted");
    a_damage_count: assert property (
        events.frame_damaged ##1 rd_at(CXERM_OFS_DAMAGED)
        |=> bus_rdata != '0) else $error("damage not counted");
endmodule : cxerm_monitor_checker
bind cxerm_monitor cxerm_monitor_checker u_chk (.clk(clk), .reset(reset), .events(events),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .irq(irq));
`default_nettype wire

// [testbench/cxerm_camera_model.sv]
// Camera side model producing decoder error pulses
`timescale 1ns/1ps
`default_nettype none
module cxerm_camera_model
    import cxerm_pkg::*;
(
    input wire logic clk,
    output var cxerm_events_s events
);
    initial events = '0;
    // Pulses back to back, quiet after; no two bursts in one step
    task automatic burst(input logic [14:0] q[$]);
        foreach (q[i]) begin
            events <= cxerm_events_s'(q[i]);
            @(posedge clk);
        end
        events <= '0;
    endtask : burst
endmodule : cxerm_camera_model
`default_nettype wire

// [testbench/cxerm_monitor_test.sv]
// Self-checking bench for the receive error monitor
`timescale 1ns/1ps
`default_nettype none
module cxerm_monitor_test
    import cxerm_pkg::*;
;
    logic clk = 0, reset = 1, bus_wr = 0, bus_rd = 0, rd_d = 0, irq;
    logic [7:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0, bus_rdata;
    logic [63:0] note;
    logic [63:0] notes[$];
    logic [14:0] q[$];
    logic [3:0] sf = 0, af = 0;
    cxerm_events_s events;
    int miscompares = 0, check_count = 0, cyc = 0, seed = 32'h9d2e, n;
    int cnt[5], crc[4];
    int bp[5] = '{14, 13, 12, 9, 8};
    logic [7:0] ad[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    cxerm_monitor i_dut (.clk(clk), .reset(reset), .events(events), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .irq(irq));
    cxerm_camera_model i_cam (.clk(clk), .events(events));
    initial forever #5 clk = ~clk;
    task automatic tally_and_finish();
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_wr <= 1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 0;
        @(posedge clk);
    endtask : wr
    // Mask lets a read ignore fields that are undefined
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        notes.push_back({m, e});
        bus_rd <= 1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 0;
        @(posedge clk);
    endtask : rd
    task automatic zeros();
        for (int a = 0; a <= 8'h28; a += 4) rd(8'(a), 32'h0);
        rd(8'hfc, 32'h0);
    endtask : zeros
    always @(posedge clk) begin
        if (rd_d) begin
            note = notes.pop_front();
            check(bus_rdata & note[63:32], note[31:0]);
        end
        rd_d <= bus_rd;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 0;
        zeros();
        q = '{15'h0800};
        i_cam.burst(q);
        rd(8'h0c, 32'h1);
        for (int k = 0; k < 5; k++) begin
            n = ($random(seed) & 7) + 1;
            q = {};
            repeat (n) q.push_back(15'(1) << bp[k]);
            cnt[k] += n;
            i_cam.burst(q);
            rd(ad[k], cnt[k]);
            rd(ad[k], cnt[k]);
        end
        for (int l = 0; l < 4; l++) begin
            n = ($random(seed) & 3) + 1;
            q = {};
            for (int j = 0; j < n; j++) q.push_back(15'(1) << (j % 2 ? 4 + l : l));
            crc[l] = n;
            af[l] = 1;
            sf[l] = n > 1;
            i_cam.burst(q);
            wr(8'h18, l);
            rd(8'h18, l);
            rd(8'h1c, crc[l]);
        end
        q = '{15'h0011};
        i_cam.burst(q);
        rd(8'h20, {af | 4'h1, sf | 4'h1});
        // Stop at the last count below overflow, then step one past it
        q = {};
        repeat (4095 - cnt[0]) q.push_back(15'h4000);
        i_cam.burst(q);
        rd(8'h00, 32'h0fff);
        q = '{15'h4000};
        i_cam.burst(q);
        rd(8'h00, 32'h1000, 32'h1000);
        wr(8'h04, $random(seed));
        rd(8'h04, cnt[1]);
        wr(8'h28, 32'h7f);
        @(posedge clk);
        check(32'(irq), 32'h1);
        wr(8'h24, 32'h7f);
        @(posedge clk);
        check(32'(irq), 32'h0);
        wr(8'h28, 32'h20);
        q = '{15'h0200};
        i_cam.burst(q);
        rd(8'h24, 32'h10);
        check(32'(irq), 32'h0);
        wr(8'h28, 32'h30);
        @(posedge clk);
        check(32'(irq), 32'h1);
        reset <= 1;
        repeat (3) @(posedge clk);
        reset <= 0;
        zeros();
        check(32'(irq), 32'h0);
        q = '{15'h0c00, 15'h0800};
        i_cam.burst(q);
        rd(8'h0c, 32'h0);
        // Last read-back compare runs on the edge that ends rd; wait one more edge
        @(posedge clk);
        tally_and_finish();
    end
endmodule : cxerm_monitor_test
`default_nettype wire
